// ==== rtl/dsad_defs.vh ====
// Constants for the data-space address decode block.
// Included by every design file of the block; definitions only.
`ifndef DSAD_DEFS_VH
`define DSAD_DEFS_VH

// Address space and data path geometry
`define DSAD_EA_W          16
`define DSAD_DATA_W        16
`define DSAD_BYTE_W        8
`define DSAD_EA_TOP_BIT    15
`define DSAD_RAM_AW        11
`define DSAD_NEAR_W        13

// Region bounds
`define DSAD_SFR_LAST      16'h0fff
`define DSAD_RAM_BASE      16'h1000
`define DSAD_RAM_BYTES     16'h1000
`define DSAD_XY_BOUNDARY   16'h1800

// Pointer steps
`define DSAD_STEP_BYTE     16'h0001
`define DSAD_STEP_WORD     16'h0002

// Address source select
`define DSAD_SRC_PTR       2'h0
`define DSAD_SRC_NEAR      2'h1
`define DSAD_SRC_FULL      2'h2

// Byte-load result operations
`define DSAD_OP_LOAD       2'h0
`define DSAD_OP_SIGN_EXT   2'h1
`define DSAD_OP_CLR_UPPER  2'h2

// Reset values
`define DSAD_ZERO_WORD     16'h0000
`define DSAD_ZERO_BYTE     8'h00

`endif

// ==== rtl/dsad_agen.v ====
// Address generator: forms an effective address from a pointer,
// a near-space field or a full direct field, and post-increments.
// Assumes pointer writeback is done by the caller from next_ptr.
`timescale 1ns/1ps
`include "dsad_defs.vh"

module dsad_agen (
  // Address sources
  input  wire [15:0] ptr,
  input  wire [12:0] near_addr,
  input  wire [15:0] full_addr,
  input  wire [1:0]  src_sel,
  // Access kind
  input  wire        byte_op,
  input  wire        post_inc,
  // Results
  output reg  [15:0] effective_address,
  output reg  [15:0] next_ptr
);

  // Source select and post-increment
  always @* begin
    case (src_sel)
      `DSAD_SRC_NEAR: effective_address = {3'h0, near_addr};
      `DSAD_SRC_FULL: effective_address = full_addr;
      default:        effective_address = ptr;
    endcase
    if (post_inc && src_sel == `DSAD_SRC_PTR) begin
      next_ptr = ptr + (byte_op ? `DSAD_STEP_BYTE : `DSAD_STEP_WORD);
    end else begin
      next_ptr = ptr;
    end
  end

endmodule

// ==== rtl/dsad_ram.v ====
// Data RAM as two byte-wide lanes sharing one word address.
// One write port and two read ports; read data registered.
`timescale 1ns/1ps
`include "dsad_defs.vh"

module dsad_ram #(
  parameter AW = 11
) (
  // Clock
  input  wire          sys_clk,
  // Write port
  input  wire [AW-1:0] wr_word,
  input  wire [1:0]    wr_lane,
  input  wire [15:0]   wr_data,
  // X read port
  input  wire [AW-1:0] x_word,
  output reg  [15:0]   x_data,
  // Y read port
  input  wire [AW-1:0] y_word,
  output reg  [15:0]   y_data
);

  reg [7:0] lane_lo [0:(1<<AW)-1];
  reg [7:0] lane_hi [0:(1<<AW)-1];

  // Shared decode, separate write strobe per lane; low byte at even address
  always @(posedge sys_clk) begin
    if (wr_lane[0]) begin
      lane_lo[wr_word] <= wr_data[7:0];
    end
    if (wr_lane[1]) begin
      lane_hi[wr_word] <= wr_data[15:8];
    end
    x_data <= {lane_hi[x_word], lane_lo[x_word]};
    y_data <= {lane_hi[y_word], lane_lo[y_word]};
  end

endmodule

// ==== rtl/dsad_top.v ====
// Data-space access logic: effective address decode, byte lanes,
// alignment trap, special-register region and dual X/Y read paths.
// Assumes one core clock; the special-register file and the program
// space window answer combinationally on their own ports.
//
// Behaviour
// - Effective addresses are 16-bit byte addresses over 64 kilobytes.
// - Separate read and write address generators work in the same cycle.
// - Top address bit clear selects data memory, set selects program window.
// - Reads beyond implemented memory return zero, word or byte.
// - Words are 16 bits, low byte even address, high byte odd.
// - Post-increment pointer adds one for bytes, two for words.
// - Byte read fetches the word, selects by bit 0, returns low.
// - Shared word decode, per-lane write strobe; byte write hits one lane.
// - Word access at odd address raises the address error trap.
// - Misaligned read completes, misaligned write suppressed; trap follows.
// - Byte load into working register keeps its high byte.
// - Sign-extend widens a byte; clear-upper zeroes the high byte.
// - Bottom four kilobytes decode to the special-register region.
// - Unused special-register addresses read as zero.
// - Near space first eight kilobytes reached by a 13-bit field.
// - Full space reached by 16-bit direct or pointer addressing.
// - X space serves all modes with separate read and write buses.
// - X read bus carries unified reads and X operand prefetch.
// - Multiply-accumulate class reads X and Y in the same cycle.
// - Modulo in X and Y; bit-reverse only on X-space writes.
// - All writes decode over unified X plus Y; boundary fixed.
`timescale 1ns/1ps
`include "dsad_defs.vh"

module dsad_top #(
  parameter RAM_AW = 11
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // Read request (X path)
  input  wire        rd_req,
  input  wire        rd_byte,
  input  wire [1:0]  rd_src,
  input  wire [15:0] rd_ptr,
  input  wire [12:0] rd_near,
  input  wire [15:0] rd_full,
  input  wire        rd_post_inc,
  input  wire [1:0]  rd_op,
  input  wire [15:0] rd_wreg_old,
  // Y read request
  input  wire        mac_req,
  input  wire [15:0] y_ea,
  // Modulo controls
  input  wire        x_mod_en,
  input  wire [15:0] x_mod_start,
  input  wire [15:0] x_mod_end,
  input  wire        y_mod_en,
  input  wire [15:0] y_mod_start,
  input  wire [15:0] y_mod_end,
  // Write request
  input  wire        wr_req,
  input  wire        wr_byte,
  input  wire [1:0]  wr_src,
  input  wire [15:0] wr_ptr,
  input  wire [12:0] wr_near,
  input  wire [15:0] wr_full,
  input  wire        wr_post_inc,
  input  wire        wr_bitrev,
  input  wire [15:0] wr_data,
  // Special-register region port
  input  wire [15:0] sfr_rdata,
  input  wire        sfr_hit,
  // Program space window port
  input  wire [15:0] psv_rdata,
  // Trap handshake
  input  wire        trap_ack,
  // Read results
  output reg         rd_valid,
  output reg  [15:0] x_rdata,
  output reg  [15:0] y_rdata,
  output reg  [15:0] rd_wreg_new,
  output reg  [15:0] rd_ptr_next,
  // Write results and region strobes
  output reg  [15:0] wr_ptr_next,
  output reg  [15:0] sfr_addr,
  output reg  [1:0]  sfr_wr_lane,
  output reg  [15:0] sfr_wdata,
  output reg  [15:0] psv_addr,
  output reg         psv_rd,
  // Trap
  output reg         addr_err_trap
);

  localparam ST_IDLE = 2'b01;
  localparam ST_READ = 2'b10;

  wire [15:0] rd_ea_raw;
  wire [15:0] wr_ea_raw;
  wire [15:0] rd_ptr_adv;
  wire [15:0] wr_ptr_adv;
  wire [15:0] ram_x;
  wire [15:0] ram_y;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] rd_ea;
  reg  [15:0] y_ea_m;
  reg  [15:0] wr_ea;
  wire [15:0] rev_ea;
  reg         rd_mis;
  reg         wr_mis;
  reg         rd_in_ram;
  reg         wr_in_ram;
  reg  [1:0]  lanes;
  reg  [15:0] lane_data;
  reg  [1:0]  ram_lanes;
  reg  [1:0]  sfr_lanes;
  // Registered read context
  reg         q_byte;
  reg         q_odd;
  reg  [1:0]  q_region;
  reg  [1:0]  q_op;
  reg  [15:0] q_wreg;
  reg  [15:0] q_sfr;
  reg         q_sfr_hit;
  reg         q_y_ram;
  reg  [15:0] word;
  reg  [7:0]  sel_byte;
  genvar      g;

  localparam RG_ZERO = 2'h0;
  localparam RG_RAM  = 2'h1;
  localparam RG_SFR  = 2'h2;
  localparam RG_PSV  = 2'h3;

  // Independent read and write address generators
  dsad_agen u_rd_agen (
    .ptr               (rd_ptr),
    .near_addr         (rd_near),
    .full_addr         (rd_full),
    .src_sel           (rd_src),
    .byte_op           (rd_byte),
    .post_inc          (rd_post_inc),
    .effective_address (rd_ea_raw),
    .next_ptr          (rd_ptr_adv)
  );

  dsad_agen u_wr_agen (
    .ptr               (wr_ptr),
    .near_addr         (wr_near),
    .full_addr         (wr_full),
    .src_sel           (wr_src),
    .byte_op           (wr_byte),
    .post_inc          (wr_post_inc),
    .effective_address (wr_ea_raw),
    .next_ptr          (wr_ptr_adv)
  );

  // Bit-reversed copy of the write address, one wire per bit
  generate
    for (g = 0; g < `DSAD_EA_W; g = g + 1) begin : g_rev
      assign rev_ea[g] = wr_ea_raw[`DSAD_EA_W-1-g];
    end
  endgenerate

  // Modulo wrap on X and Y reads, bit reversal on X writes only
  always @* begin
    rd_ea = rd_ea_raw;
    if (x_mod_en && rd_ea_raw > x_mod_end) begin
      rd_ea = x_mod_start;
    end
    y_ea_m = y_ea;
    if (y_mod_en && y_ea > y_mod_end) begin
      y_ea_m = y_mod_start;
    end
    wr_ea = wr_ea_raw;
    if (wr_bitrev && !wr_byte && wr_ea_raw < `DSAD_XY_BOUNDARY) begin
      wr_ea = {rev_ea[15:1], 1'b0};
    end
  end

  // Decode and write lanes
  always @* begin
    rd_mis    = rd_req && !rd_byte && rd_ea[0];
    wr_mis    = wr_req && !wr_byte && wr_ea[0];
    rd_in_ram = !rd_ea[`DSAD_EA_TOP_BIT] && rd_ea >= `DSAD_RAM_BASE
                && rd_ea < `DSAD_RAM_BASE + `DSAD_RAM_BYTES;
    // Unified X plus Y decode for every write
    wr_in_ram = wr_ea >= `DSAD_RAM_BASE
                && wr_ea < `DSAD_RAM_BASE + `DSAD_RAM_BYTES;
    if (wr_byte) begin
      lanes     = wr_ea[0] ? 2'h2 : 2'h1;
      lane_data = {wr_data[7:0], wr_data[7:0]};
    end else begin
      lanes     = 2'h3;
      lane_data = wr_data;
    end
    ram_lanes = (wr_req && !wr_mis && wr_in_ram) ? lanes : 2'h0;
    sfr_lanes = (wr_req && !wr_mis && wr_ea <= `DSAD_SFR_LAST) ? lanes : 2'h0;
  end

  dsad_ram #(.AW(RAM_AW)) u_ram (
    .sys_clk (sys_clk),
    .wr_word (wr_ea[RAM_AW:1]),
    .wr_lane (ram_lanes),
    .wr_data (lane_data),
    .x_word  (rd_ea[RAM_AW:1]),
    .x_data  (ram_x),
    .y_word  (y_ea_m[RAM_AW:1]),
    .y_data  (ram_y)
  );

  // Read state: two cycles from request to data
  always @* begin
    case (state)
      ST_IDLE: next_state = rd_req ? ST_READ : ST_IDLE;
      ST_READ: next_state = rd_req ? ST_READ : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Capture request context
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      q_byte      <= 1'b0;
      q_odd       <= 1'b0;
      q_region    <= RG_ZERO;
      q_op        <= `DSAD_OP_LOAD;
      q_wreg      <= `DSAD_ZERO_WORD;
      q_sfr       <= `DSAD_ZERO_WORD;
      q_sfr_hit   <= 1'b0;
      q_y_ram     <= 1'b0;
      rd_ptr_next <= `DSAD_ZERO_WORD;
      wr_ptr_next <= `DSAD_ZERO_WORD;
      sfr_addr    <= `DSAD_ZERO_WORD;
      sfr_wr_lane <= 2'h0;
      sfr_wdata   <= `DSAD_ZERO_WORD;
      psv_addr    <= `DSAD_ZERO_WORD;
      psv_rd      <= 1'b0;
    end else begin
      state     <= next_state;
      q_byte    <= rd_byte;
      q_odd     <= rd_ea[0];
      q_op      <= rd_op;
      q_wreg    <= rd_wreg_old;
      q_sfr     <= sfr_rdata;
      q_sfr_hit <= sfr_hit;
      q_y_ram   <= mac_req && y_ea_m >= `DSAD_RAM_BASE
                   && y_ea_m < `DSAD_RAM_BASE + `DSAD_RAM_BYTES;
      if (rd_ea[`DSAD_EA_TOP_BIT]) begin
        q_region <= RG_PSV;
      end else if (rd_ea <= `DSAD_SFR_LAST) begin
        q_region <= RG_SFR;
      end else if (rd_in_ram) begin
        q_region <= RG_RAM;
      end else begin
        q_region <= RG_ZERO;
      end
      rd_ptr_next <= rd_req ? rd_ptr_adv : rd_ptr;
      wr_ptr_next <= wr_req ? wr_ptr_adv : wr_ptr;
      sfr_addr    <= wr_ea;
      sfr_wr_lane <= sfr_lanes;
      sfr_wdata   <= lane_data;
      psv_addr    <= rd_ea;
      psv_rd      <= rd_req && rd_ea[`DSAD_EA_TOP_BIT];
    end
  end

  // Select word and byte from the addressed region
  always @* begin
    case (q_region)
      RG_RAM:  word = ram_x;
      RG_SFR:  word = q_sfr_hit ? q_sfr : `DSAD_ZERO_WORD;
      RG_PSV:  word = psv_rdata;
      default: word = `DSAD_ZERO_WORD;
    endcase
    sel_byte = q_odd ? word[15:8] : word[7:0];
  end

  // Read results, X and Y paths and trap request
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      rd_valid      <= 1'b0;
      x_rdata       <= `DSAD_ZERO_WORD;
      y_rdata       <= `DSAD_ZERO_WORD;
      rd_wreg_new   <= `DSAD_ZERO_WORD;
      addr_err_trap <= 1'b0;
    end else begin
      // Misaligned reads still complete; the trap is raised one cycle before the data
      rd_valid <= (state == ST_READ);
      if (state == ST_READ) begin
        x_rdata <= q_byte ? {`DSAD_ZERO_BYTE, sel_byte} : word;
        y_rdata <= q_y_ram ? ram_y : `DSAD_ZERO_WORD;
        case (q_op)
          `DSAD_OP_SIGN_EXT:  rd_wreg_new <= {{8{sel_byte[7]}}, sel_byte};
          `DSAD_OP_CLR_UPPER: rd_wreg_new <= {`DSAD_ZERO_BYTE, sel_byte};
          default: rd_wreg_new <= q_byte ? {q_wreg[15:8], sel_byte} : word;
        endcase
      end
      // New fault wins over acknowledge; held until taken
      if (rd_mis || wr_mis) begin
        addr_err_trap <= 1'b1;
      end else if (trap_ack) begin
        addr_err_trap <= 1'b0;
      end
    end
  end

endmodule

// ==== tb/dsad_far_model.sv ====
// Far-side model: one special register, junk elsewhere, program window.
// Assumes the read address is shown on ea in the request cycle.
`timescale 1ns/1ps
module dsad_far_model #(
  parameter [15:0] SFR_A = 16'h0040
) (
  // Clock and read address
  input  wire        sys_clk,
  input  wire [15:0] ea,
  // Special-register writes
  input  wire [15:0] sfr_addr,
  input  wire [1:0]  sfr_wr_lane,
  input  wire [15:0] sfr_wdata,
  // Program window
  input  wire [15:0] psv_addr,
  input  wire        psv_rd,
  output wire [15:0] sfr_rdata,
  output wire        sfr_hit,
  output wire [15:0] psv_rdata
);
  reg [15:0] sreg = 16'h0000;
  reg [15:0] junk = 16'h0000;
  // Lane writes and a changing junk pattern
  always @(posedge sys_clk) begin
    junk <= junk + 16'h3c3d;
    if (sfr_addr[15:1] == SFR_A[15:1] && sfr_wr_lane[0])
      sreg[7:0] <= sfr_wdata[7:0];
    if (sfr_addr[15:1] == SFR_A[15:1] && sfr_wr_lane[1])
      sreg[15:8] <= sfr_wdata[15:8];
  end
  // Window answers while its strobe stands, junk otherwise
  assign psv_rdata = psv_rd ? {8'h5a, psv_addr[7:0]} : junk;
  // Unused places show changing junk that must be masked
  assign sfr_hit   = (ea[15:1] == SFR_A[15:1]);
  assign sfr_rdata = sfr_hit ? sreg : junk;
endmodule

// ==== tb/dsad_checker.sv ====
// Port assertions for the decode block.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
module dsad_checker #(
  parameter RAM_AW = 11
) (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst_b,
  // Requests
  input wire        rd_req,
  input wire        rd_byte,
  input wire [1:0]  rd_src,
  input wire [15:0] rd_ptr,
  input wire [15:0] rd_full,
  input wire        rd_post_inc,
  input wire        wr_req,
  input wire        wr_byte,
  input wire [1:0]  wr_src,
  input wire [15:0] wr_full,
  input wire        trap_ack,
  // Results
  input wire        rd_valid,
  input wire [15:0] x_rdata,
  input wire [15:0] rd_ptr_next,
  input wire [1:0]  sfr_wr_lane,
  input wire        psv_rd,
  input wire        addr_err_trap
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Read timing, byte placement, pointer step and window routing
  a_rd_latency: assert property (rd_req |-> ##2 rd_valid)
    else $error("read answer late");
  a_valid_cause: assert property (rd_valid |-> $past(rd_req, 2))
    else $error("stray read answer");
  a_byte_upper: assert property (rd_valid && $past(rd_byte, 2) |-> x_rdata[15:8] == 8'h00)
    else $error("byte read upper not zero");
  a_ptr_step: assert property (rd_req && rd_src == 2'h0 && rd_post_inc |=>
    rd_ptr_next == $past(rd_ptr) + ($past(rd_byte) ? 16'h0001 : 16'h0002))
    else $error("pointer step wrong");
  a_psv_route: assert property (rd_req && rd_src == 2'h2 && rd_full[15] |=> psv_rd)
    else $error("window read missing");
  // Write lanes and the trap
  a_lane_odd: assert property (wr_req && wr_byte && wr_src == 2'h2 &&
    wr_full < 16'h1000 && wr_full[0] |=> sfr_wr_lane == 2'h2)
    else $error("odd byte lane wrong");
  a_odd_word: assert property (wr_req && !wr_byte && wr_src == 2'h2 &&
    wr_full[0] |=> addr_err_trap && sfr_wr_lane == 2'h0)
    else $error("misaligned write not trapped");
  a_trap_hold: assert property (addr_err_trap && !trap_ack |=> addr_err_trap)
    else $error("trap dropped early");
endmodule
bind dsad_top dsad_checker #(.RAM_AW(RAM_AW)) u_chk (.*);

// ==== tb/dsad_top_tb_top.sv ====
// Self-checking bench for the decode block.
// Assumes the design, far model and checker are compiled first.
`timescale 1ns/1ps
module dsad_top_tb_top;
  reg         sys_clk = 1'b0;
  reg         rst_b, rd_req, rd_byte, rd_post_inc, mac_req, x_mod_en, y_mod_en;
  reg         wr_req, wr_byte, wr_post_inc, wr_bitrev, trap_ack;
  reg  [1:0]  rd_src, rd_op, wr_src;
  reg  [12:0] rd_near, wr_near;
  reg  [15:0] rd_ptr, rd_full, rd_wreg_old, y_ea, x_mod_start, x_mod_end;
  reg  [15:0] y_mod_start, y_mod_end, wr_ptr, wr_full, wr_data;
  wire        rd_valid, sfr_hit, psv_rd, addr_err_trap;
  wire [1:0]  sfr_wr_lane;
  wire [15:0] x_rdata, y_rdata, rd_wreg_new, rd_ptr_next, wr_ptr_next;
  wire [15:0] sfr_rdata, sfr_addr, sfr_wdata, psv_addr, psv_rdata;
  integer     mismatches = 0;
  integer     n_compared = 0;
  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;
  dsad_top #(.RAM_AW(11)) dut (.*);
  dsad_far_model far (.*, .ea(rd_full));
  task ck(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One read; waits a bounded time for the answer
  task rd(input [1:0] s, input [15:0] a, input b, input [1:0] op);
    integer i;
    begin
      @(posedge sys_clk);
      {rd_req, rd_src, rd_byte, rd_op} <= {1'b1, s, b, op};
      {rd_ptr, rd_full, rd_near} <= {a, a, a[12:0]};
      @(posedge sys_clk);
      {rd_req, mac_req} <= 2'h0;
      @(posedge sys_clk);
      #1 i = 0;
      while (i < 3 && rd_valid !== 1'b1) begin
        @(posedge sys_clk);
        #1 i = i + 1;
      end
      ck({15'h0000, rd_valid}, 16'h0001);
    end
  endtask
  // One write; returns just after its request edge
  task wr(input [15:0] a, input b, input [15:0] d);
    begin
      @(posedge sys_clk);
      {wr_req, wr_src, wr_byte} <= {1'b1, 2'h2, b};
      {wr_full, wr_data} <= {a, d};
      @(posedge sys_clk);
      wr_req <= 1'b0;
      #1;
    end
  endtask
  task t_lanes;
    begin
      wr(16'h1002, 1'b0, 16'h1234);
      rd(2'h2, 16'h1002, 1'b0, 2'h0);
      ck(x_rdata, 16'h1234);
      rd(2'h2, 16'h1003, 1'b1, 2'h0);
      ck(x_rdata, 16'h0012);
      wr(16'h1003, 1'b1, 16'h77ab);
      rd_wreg_old <= 16'h5500;
      rd(2'h2, 16'h1002, 1'b1, 2'h0);
      ck(x_rdata, 16'h0034);
      rd(2'h2, 16'h1003, 1'b1, 2'h0);
      ck(rd_wreg_new, 16'h55ab);
      rd(2'h2, 16'h1003, 1'b1, 2'h1);
      ck(rd_wreg_new, 16'hffab);
      rd(2'h2, 16'h1003, 1'b1, 2'h2);
      ck(rd_wreg_new, 16'h00ab);
      wr(16'h1802, 1'b0, 16'h6789);
      rd(2'h2, 16'h1802, 1'b0, 2'h0);
      ck(x_rdata, 16'h6789);
    end
  endtask
  task t_regions;
    begin
      rd(2'h2, 16'h2000, 1'b0, 2'h0);
      ck(x_rdata, 16'h0000);
      rd(2'h2, 16'h7fff, 1'b1, 2'h0);
      ck(x_rdata, 16'h0000);
      wr(16'h0040, 1'b0, 16'hc3a5);
      ck({14'h0000, sfr_wr_lane}, 16'h0003);
      rd(2'h2, 16'h0040, 1'b0, 2'h0);
      ck(x_rdata, 16'hc3a5);
      rd(2'h2, 16'h0100, 1'b0, 2'h0);
      ck(x_rdata, 16'h0000);
      wr(16'h0101, 1'b1, 16'h00ee);
      rd(2'h2, 16'h8010, 1'b0, 2'h0);
      ck(x_rdata, 16'h5a10);
    end
  endtask
  // Read and write pointers stepping in one cycle
  task t_ptrs;
    begin
      @(posedge sys_clk);
      {rd_req, rd_src, rd_byte, rd_post_inc} <= {1'b1, 2'h0, 1'b1, 1'b1};
      {rd_ptr, rd_full, wr_ptr, wr_data} <= {16'h1002, 16'h1002, 16'h1010, 16'h0f0f};
      {wr_req, wr_src, wr_byte, wr_post_inc} <= {1'b1, 2'h0, 1'b0, 1'b1};
      @(posedge sys_clk);
      {rd_req, wr_req} <= 2'h0;
      #1 ck(rd_ptr_next, 16'h1003);
      ck(wr_ptr_next, 16'h1012);
      rd(2'h1, 16'h1010, 1'b0, 2'h0);
      ck(x_rdata, 16'h0f0f);
      rd(2'h0, 16'h1002, 1'b0, 2'h0);
      ck(x_rdata, 16'hab34);
      rd_post_inc <= 1'b0;
    end
  endtask
  task ack;
    begin
      @(posedge sys_clk);
      trap_ack <= 1'b1;
      @(posedge sys_clk);
      trap_ack <= 1'b0;
      #1 ck({15'h0000, addr_err_trap}, 16'h0000);
    end
  endtask
  task t_trap;
    begin
      wr(16'h1004, 1'b0, 16'h4444);
      wr(16'h1005, 1'b0, 16'hdead);
      ck({15'h0000, addr_err_trap}, 16'h0001);
      wr(16'h0041, 1'b0, 16'hdead);
      ck({14'h0000, sfr_wr_lane}, 16'h0000);
      repeat (3) @(posedge sys_clk);
      #1 ck({15'h0000, addr_err_trap}, 16'h0001);
      ack;
      rd(2'h2, 16'h1004, 1'b0, 2'h0);
      ck(x_rdata, 16'h4444);
      rd(2'h2, 16'h1003, 1'b0, 2'h0);
      ck(x_rdata, 16'hab34);
      ck({15'h0000, addr_err_trap}, 16'h0001);
      ack;
    end
  endtask
  // X and Y reads together, then with modulo wrap
  task t_dual;
    begin
      {y_ea, mac_req} <= {16'h1004, 1'b1};
      rd(2'h2, 16'h1002, 1'b0, 2'h0);
      ck(x_rdata, 16'hab34);
      ck(y_rdata, 16'h4444);
      wr_bitrev <= 1'b1;
      wr(16'h0008, 1'b0, 16'h5a5a);
      ck({14'h0000, sfr_wr_lane}, 16'h0000);
      wr_bitrev <= 1'b0;
      rd(2'h2, 16'h1000, 1'b0, 2'h0);
      ck(x_rdata, 16'h5a5a);
      {x_mod_en, x_mod_start, x_mod_end} <= {1'b1, 16'h1002, 16'h1004};
      {y_mod_en, y_mod_start, y_mod_end} <= {1'b1, 16'h1004, 16'h1006};
      {y_ea, mac_req} <= {16'h1008, 1'b1};
      rd(2'h0, 16'h1006, 1'b0, 2'h0);
      ck(x_rdata, 16'hab34);
      ck(y_rdata, 16'h4444);
    end
  endtask
  task give_verdict;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    {rst_b, rd_req, rd_byte, rd_post_inc, mac_req, x_mod_en, y_mod_en, wr_req,
     wr_byte, wr_post_inc, wr_bitrev, trap_ack, rd_src, rd_op, wr_src, rd_near,
     wr_near, rd_ptr, rd_full, rd_wreg_old, y_ea, x_mod_start, x_mod_end,
     y_mod_start, y_mod_end, wr_ptr, wr_full, wr_data} <= '0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_lanes;
    t_regions;
    t_ptrs;
    t_trap;
    t_dual;
    give_verdict;
  end
  // Hang guard
  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches = mismatches + 1;
    give_verdict;
  end
endmodule
